//--- design/serial_frame_pkg.sv
// Constants, configuration and word types shared by the serial frame assembler.
package serial_frame_pkg;

  localparam int CLK_FREQ_HZ_DEF = 10_000_000;
  localparam int RATE_COUNT = 10;
  localparam int BAUD_TABLE [RATE_COUNT] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 115200;
  localparam int CNT_WIDTH = 16;
  localparam int FIFO_DEPTH_DEF = 8;

  localparam logic [3:0] BAUD_SEL_DEF = 4'h6;
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [3:0] DATA_BITS_LONG = 4'h8;
  localparam logic [3:0] DATA_BITS_SHORT = 4'h7;
  localparam logic [3:0] STOP_BITS_ONE = 4'h1;
  localparam logic [3:0] STOP_BITS_TWO = 4'h2;
  localparam logic [10:0] IDLE_CHARS_DEF = 11'h005;
  localparam logic [10:0] IDLE_CHARS_MAX = 11'h7D0;
  localparam logic [10:0] MAX_SIZE_DEF = 11'h640;
  localparam logic [10:0] MAX_SIZE_MIN = 11'h001;
  localparam logic [10:0] MAX_SIZE_MAX = 11'h640;
  localparam logic [15:0] UDP_PORT_ONE = 16'h22B1;
  localparam logic [15:0] UDP_PORT_TWO = 16'h22B2;
  localparam int PORT_ONE = 1;
  localparam int PORT_TWO = 2;

  typedef enum logic [1:0] {
    PARITY_NONE = 2'b00,
    PARITY_ODD = 2'b01,
    PARITY_EVEN = 2'b10
  } parity_type;

  typedef struct packed {
    logic [3:0] baud_sel;
    logic seven_bits;
    parity_type parity;
    logic two_stop;
    logic [10:0] idle_chars;
    logic [10:0] max_size;
    logic flow_rts_cts;
    logic protocol_none;
    logic check_code;
    logic bridge_mode;
    logic rs485_sel;
  } port_cfg_type;

  localparam port_cfg_type CFG_DEF = '{
    baud_sel: BAUD_SEL_DEF,
    seven_bits: 1'b0,
    parity: PARITY_NONE,
    two_stop: 1'b0,
    idle_chars: IDLE_CHARS_DEF,
    max_size: MAX_SIZE_DEF,
    flow_rts_cts: 1'b0,
    protocol_none: 1'b1,
    check_code: 1'b0,
    bridge_mode: 1'b0,
    rs485_sel: 1'b0
  };

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic parity_err;
    logic framing_err;
    logic code_ok;
  } frame_word_type;

  localparam int WORD_WIDTH = $bits(frame_word_type);

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100,
    RX_STOP2 = 3'b101
  } rx_state_type;

endpackage

//--- design/frame_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module frame_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : bad_params
      $error("FIFO depth must be a power of two of at least 2.");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic do_write, do_read;

  always_comb begin
    in_ready_out = (count_ff != (AW+1)'(DEPTH));
    out_valid_out = (count_ff != '0);
    out_data_out = mem_ff[rd_ptr_ff];
    do_write = in_valid_in && in_ready_out;
    do_read = out_valid_out && out_ready_in;
    nxt_wr_ptr = do_write ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = do_read ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count = count_ff;
    if (do_write && !do_read) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (do_read && !do_write) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_write) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

endmodule

//--- design/serial_port_frame_assembler.sv
// Serial receiver that groups characters into frames for the network side.
`timescale 1ns/1ps
module serial_port_frame_assembler
  import serial_frame_pkg::*;
#(
  parameter int CLK_FREQ_HZ = CLK_FREQ_HZ_DEF,
  parameter int PORT_NUMBER = PORT_ONE,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire port_cfg_type cfg_in,
  input wire logic cfg_load_in,
  output port_cfg_type cfg_out,
  input wire logic rxd_in,
  input wire logic rts_in,
  output logic cts_out,
  output logic rts_active_out,
  output logic rs485_mode_out,
  output logic frame_valid_out,
  input wire logic frame_ready_in,
  output frame_word_type frame_word_out,
  output logic [15:0] dest_port_out,
  output logic broadcast_out,
  output logic overrun_out,
  input wire logic net_valid_in,
  output logic net_ready_out
);

  generate
    if (CLK_FREQ_HZ / BAUD_MAX < 4 || CLK_FREQ_HZ / BAUD_MIN >= (1 << CNT_WIDTH)) begin : bad_clock
      $error("Clock rate cannot serve the bit rate range.");
    end
    if (PORT_NUMBER != PORT_ONE && PORT_NUMBER != PORT_TWO) begin : bad_port
      $error("Port number must be one or two.");
    end
  endgenerate

  function automatic logic [CNT_WIDTH-1:0] bit_len_of(input logic [3:0] sel);
    logic [CNT_WIDTH-1:0] len;
    len = CNT_WIDTH'(CLK_FREQ_HZ / BAUD_TABLE[BAUD_SEL_DEF]);
    for (int i = 0; i < RATE_COUNT; i++) begin
      if (sel == 4'(i)) begin
        len = CNT_WIDTH'(CLK_FREQ_HZ / BAUD_TABLE[i]);
      end
    end
    return len;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration loaded with defaults at reset and replaced on cfg_load_in.

  port_cfg_type cfg_ff, nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (cfg_load_in) begin
      nxt_cfg = cfg_in;
      if (cfg_in.baud_sel >= 4'(RATE_COUNT)) begin
        nxt_cfg.baud_sel = BAUD_SEL_DEF;
      end
      if (cfg_in.parity != PARITY_ODD && cfg_in.parity != PARITY_EVEN) begin
        nxt_cfg.parity = PARITY_NONE;
      end
      if (cfg_in.idle_chars > IDLE_CHARS_MAX) begin
        nxt_cfg.idle_chars = IDLE_CHARS_MAX;
      end
      if (cfg_in.max_size < MAX_SIZE_MIN) begin
        nxt_cfg.max_size = MAX_SIZE_MIN;
      end else if (cfg_in.max_size > MAX_SIZE_MAX) begin
        nxt_cfg.max_size = MAX_SIZE_MAX;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_ff <= CFG_DEF;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  logic [CNT_WIDTH-1:0] bit_len;
  logic [3:0] data_bits;
  logic [3:0] char_bits;
  logic parity_en;
  logic [15:0] gap_limit;

  always_comb begin
    bit_len = bit_len_of(cfg_ff.baud_sel);
    data_bits = cfg_ff.seven_bits ? DATA_BITS_SHORT : DATA_BITS_LONG;
    parity_en = (cfg_ff.parity != PARITY_NONE);
    char_bits = 4'(START_BITS + data_bits + {3'h0, parity_en} + (cfg_ff.two_stop ? STOP_BITS_TWO : STOP_BITS_ONE));
    gap_limit = 16'({5'h00, cfg_ff.idle_chars} * {12'h000, char_bits});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers with agreement of the second and third stages.

  logic [2:0] rxd_sync_ff, nxt_rxd_sync;
  logic [2:0] rts_sync_ff, nxt_rts_sync;
  logic rx_level_ff, nxt_rx_level;
  logic rts_level_ff, nxt_rts_level;

  always_comb begin
    nxt_rxd_sync = {rxd_sync_ff[1:0], rxd_in};
    nxt_rts_sync = {rts_sync_ff[1:0], rts_in};
    nxt_rx_level = (rxd_sync_ff[1] == rxd_sync_ff[2]) ? rxd_sync_ff[1] : rx_level_ff;
    nxt_rts_level = (rts_sync_ff[1] == rts_sync_ff[2]) ? rts_sync_ff[1] : rts_level_ff;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rxd_sync_ff <= 3'h7;
      rts_sync_ff <= 3'h0;
      rx_level_ff <= 1'b1;
      rts_level_ff <= 1'b0;
    end else begin
      rxd_sync_ff <= nxt_rxd_sync;
      rts_sync_ff <= nxt_rts_sync;
      rx_level_ff <= nxt_rx_level;
      rts_level_ff <= nxt_rts_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character receiver.

  rx_state_type state_ff, nxt_state;
  logic [CNT_WIDTH-1:0] cnt_ff, nxt_cnt;
  logic [3:0] bitn_ff, nxt_bitn;
  logic [7:0] shift_ff, nxt_shift;
  logic ones_ff, nxt_ones;
  logic perr_ff, nxt_perr;
  logic ferr_ff, nxt_ferr;
  logic byte_strobe_ff, nxt_byte_strobe;
  logic [7:0] byte_ff, nxt_byte;
  logic byte_perr_ff, nxt_byte_perr;
  logic byte_ferr_ff, nxt_byte_ferr;
  logic cnt_done;
  logic [CNT_WIDTH-1:0] bit_reload;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bitn = bitn_ff;
    nxt_shift = shift_ff;
    nxt_ones = ones_ff;
    nxt_perr = perr_ff;
    nxt_ferr = ferr_ff;
    nxt_byte_strobe = 1'b0;
    nxt_byte = byte_ff;
    nxt_byte_perr = byte_perr_ff;
    nxt_byte_ferr = byte_ferr_ff;
    cnt_done = (cnt_ff == '0);
    bit_reload = CNT_WIDTH'(bit_len - 1'b1);
    if (state_ff != RX_IDLE && !cnt_done) begin
      nxt_cnt = CNT_WIDTH'(cnt_ff - 1'b1);
    end
    unique case (state_ff)
      RX_IDLE: begin
        if (!rx_level_ff) begin
          nxt_state = RX_START;
          nxt_cnt = CNT_WIDTH'(bit_len >> 1);
        end
      end
      RX_START: begin
        if (cnt_done) begin
          nxt_cnt = bit_reload;
          nxt_bitn = 4'h0;
          nxt_ones = 1'b0;
          nxt_perr = 1'b0;
          nxt_ferr = 1'b0;
          nxt_state = rx_level_ff ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (cnt_done) begin
          nxt_cnt = bit_reload;
          nxt_shift = {rx_level_ff, shift_ff[7:1]};
          nxt_ones = ones_ff ^ rx_level_ff;
          nxt_bitn = 4'(bitn_ff + 1'b1);
          if (bitn_ff == 4'(data_bits - 1'b1)) begin
            nxt_state = parity_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (cnt_done) begin
          nxt_cnt = bit_reload;
          nxt_perr = (cfg_ff.parity == PARITY_ODD) ? !(ones_ff ^ rx_level_ff) : (ones_ff ^ rx_level_ff);
          nxt_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (cnt_done) begin
          nxt_cnt = bit_reload;
          nxt_ferr = !rx_level_ff;
          if (cfg_ff.two_stop) begin
            nxt_state = RX_STOP2;
          end else begin
            nxt_state = RX_IDLE;
            nxt_byte_strobe = 1'b1;
            nxt_byte = cfg_ff.seven_bits ? {1'b0, shift_ff[7:1]} : shift_ff;
            nxt_byte_perr = perr_ff;
            nxt_byte_ferr = !rx_level_ff;
          end
        end
      end
      RX_STOP2: begin
        if (cnt_done) begin
          nxt_state = RX_IDLE;
          nxt_byte_strobe = 1'b1;
          nxt_byte = cfg_ff.seven_bits ? {1'b0, shift_ff[7:1]} : shift_ff;
          nxt_byte_perr = perr_ff;
          nxt_byte_ferr = ferr_ff || !rx_level_ff;
        end
      end
      default: begin
        nxt_state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= RX_IDLE;
      cnt_ff <= '0;
      bitn_ff <= 4'h0;
      shift_ff <= 8'h00;
      ones_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      byte_strobe_ff <= 1'b0;
      byte_ff <= 8'h00;
      byte_perr_ff <= 1'b0;
      byte_ferr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bitn_ff <= nxt_bitn;
      shift_ff <= nxt_shift;
      ones_ff <= nxt_ones;
      perr_ff <= nxt_perr;
      ferr_ff <= nxt_ferr;
      byte_strobe_ff <= nxt_byte_strobe;
      byte_ff <= nxt_byte;
      byte_perr_ff <= nxt_byte_perr;
      byte_ferr_ff <= nxt_byte_ferr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly, idle gap timing and size limit.

  logic [CNT_WIDTH-1:0] gap_cyc_ff, nxt_gap_cyc;
  logic [15:0] gap_bits_ff, nxt_gap_bits;
  logic [7:0] staged_ff, nxt_staged;
  logic staged_valid_ff, nxt_staged_valid;
  logic [10:0] count_ff, nxt_count;
  logic frame_perr_ff, nxt_frame_perr;
  logic frame_ferr_ff, nxt_frame_ferr;
  logic [7:0] sum_ff, nxt_sum;
  logic overrun_ff, nxt_overrun;
  logic push;
  frame_word_type push_word;
  logic fifo_in_ready;
  logic idle_close;
  logic size_close;
  logic [WORD_WIDTH-1:0] fifo_out_data;

  always_comb begin
    nxt_gap_cyc = gap_cyc_ff;
    nxt_gap_bits = gap_bits_ff;
    nxt_staged = staged_ff;
    nxt_staged_valid = staged_valid_ff;
    nxt_count = count_ff;
    nxt_frame_perr = frame_perr_ff;
    nxt_frame_ferr = frame_ferr_ff;
    nxt_sum = sum_ff;
    push = 1'b0;
    push_word = '0;
    idle_close = staged_valid_ff && (gap_bits_ff > gap_limit);
    size_close = staged_valid_ff && (count_ff >= cfg_ff.max_size);
    if (byte_strobe_ff) begin
      nxt_gap_cyc = '0;
      nxt_gap_bits = 16'h0000;
    end else if (staged_valid_ff && gap_bits_ff <= gap_limit) begin
      if (gap_cyc_ff == CNT_WIDTH'(bit_len - 1'b1)) begin
        nxt_gap_cyc = '0;
        nxt_gap_bits = 16'(gap_bits_ff + 1'b1);
      end else begin
        nxt_gap_cyc = CNT_WIDTH'(gap_cyc_ff + 1'b1);
      end
    end
    if (cfg_ff.protocol_none) begin
      nxt_staged_valid = 1'b0;
      nxt_count = 11'h000;
      nxt_frame_perr = 1'b0;
      nxt_frame_ferr = 1'b0;
      nxt_sum = 8'h00;
    end else if (size_close || idle_close) begin
      push = 1'b1;
      push_word.data = staged_ff;
      push_word.last = 1'b1;
      push_word.parity_err = frame_perr_ff;
      push_word.framing_err = frame_ferr_ff;
      push_word.code_ok = cfg_ff.check_code ? (sum_ff == staged_ff) : 1'b1;
      nxt_staged_valid = 1'b0;
      nxt_count = 11'h000;
      nxt_frame_perr = 1'b0;
      nxt_frame_ferr = 1'b0;
      nxt_sum = 8'h00;
    end else if (byte_strobe_ff) begin
      if (staged_valid_ff) begin
        push = 1'b1;
        push_word.data = staged_ff;
        push_word.code_ok = 1'b1;
        nxt_sum = 8'(sum_ff + staged_ff);
      end
      nxt_staged = byte_ff;
      nxt_staged_valid = 1'b1;
      nxt_count = 11'(count_ff + 1'b1);
      nxt_frame_perr = frame_perr_ff || (parity_en && byte_perr_ff);
      nxt_frame_ferr = frame_ferr_ff || byte_ferr_ff;
    end
    nxt_overrun = push && !fifo_in_ready;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gap_cyc_ff <= '0;
      gap_bits_ff <= 16'h0000;
      staged_ff <= 8'h00;
      staged_valid_ff <= 1'b0;
      count_ff <= 11'h000;
      frame_perr_ff <= 1'b0;
      frame_ferr_ff <= 1'b0;
      sum_ff <= 8'h00;
      overrun_ff <= 1'b0;
    end else begin
      gap_cyc_ff <= nxt_gap_cyc;
      gap_bits_ff <= nxt_gap_bits;
      staged_ff <= nxt_staged;
      staged_valid_ff <= nxt_staged_valid;
      count_ff <= nxt_count;
      frame_perr_ff <= nxt_frame_perr;
      frame_ferr_ff <= nxt_frame_ferr;
      sum_ff <= nxt_sum;
      overrun_ff <= nxt_overrun;
    end
  end

  frame_fifo #(
    .WIDTH(WORD_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) rx_buffer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_word),
    .out_valid_out(frame_valid_out),
    .out_ready_in(frame_ready_in),
    .out_data_out(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs.

  always_comb begin
    frame_word_out = frame_word_type'(fifo_out_data);
    cfg_out = cfg_ff;
    cts_out = !cfg_ff.flow_rts_cts || fifo_in_ready;
    rts_active_out = cfg_ff.flow_rts_cts && rts_level_ff;
    rs485_mode_out = (PORT_NUMBER == PORT_TWO) && cfg_ff.rs485_sel;
    dest_port_out = (PORT_NUMBER == PORT_ONE) ? UDP_PORT_ONE : UDP_PORT_TWO;
    broadcast_out = cfg_ff.bridge_mode;
    overrun_out = overrun_ff;
    net_ready_out = cfg_ff.protocol_none && net_valid_in;
  end

endmodule

//--- sim/serial_frame_asserts.sv
// Concurrent checks on the ports of the serial frame assembler.
`timescale 1ns/1ps
module serial_frame_asserts
  import serial_frame_pkg::*;
#(
  parameter int CLK_FREQ_HZ = CLK_FREQ_HZ_DEF,
  parameter int PORT_NUMBER = PORT_ONE,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire port_cfg_type cfg_in,
  input wire logic cfg_load_in,
  input wire port_cfg_type cfg_out,
  input wire logic cts_out,
  input wire logic rts_active_out,
  input wire logic rs485_mode_out,
  input wire logic frame_valid_out,
  input wire logic frame_ready_in,
  input wire frame_word_type frame_word_out,
  input wire logic [15:0] dest_port_out,
  input wire logic broadcast_out,
  input wire logic overrun_out,
  input wire logic net_valid_in,
  input wire logic net_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  //////////////////////////////////////////////////////////////////////////////
  cts_idle_a: assert property (!cfg_out.flow_rts_cts |-> cts_out)
    else $error("clear to send dropped without flow control");
  rts_gate_a: assert property (rts_active_out |-> cfg_out.flow_rts_cts)
    else $error("request reported without flow control");
  cts_full_a: assert property (overrun_out && $past(cfg_out.flow_rts_cts) |-> !$past(cts_out))
    else $error("word lost while clear to send was high");
  size_load_a: assert property (cfg_load_in && cfg_in.max_size inside {[MAX_SIZE_MIN:MAX_SIZE_MAX]}
    |=> cfg_out.max_size == $past(cfg_in.max_size))
    else $error("frame size setting not taken");
  cfg_hold_a: assert property (!cfg_load_in |=> $stable(cfg_out))
    else $error("configuration changed without a load");
  rate_clamp_a: assert property (cfg_load_in && cfg_in.baud_sel >= 4'hA |=> cfg_out.baud_sel == BAUD_SEL_DEF)
    else $error("unknown rate not replaced by default");
  idle_clamp_a: assert property (cfg_load_in && cfg_in.idle_chars > IDLE_CHARS_MAX
    |=> cfg_out.idle_chars == IDLE_CHARS_MAX)
    else $error("idle gap not limited");
  port_mode_a: assert property (rs485_mode_out == (PORT_NUMBER == 2 && cfg_out.rs485_sel))
    else $error("line mode wrong for this port");
  bridge_a: assert property (broadcast_out == cfg_out.bridge_mode)
    else $error("broadcast flag does not follow bridge mode");
  udp_port_a: assert property (dest_port_out == (PORT_NUMBER == 2 ? UDP_PORT_TWO : UDP_PORT_ONE))
    else $error("network port number wrong");
  net_drop_a: assert property (cfg_out.protocol_none |-> net_ready_out == net_valid_in)
    else $error("network data not discarded");
  no_push_a: assert property (cfg_out.protocol_none && $past(cfg_out.protocol_none) && !frame_valid_out
    |=> !frame_valid_out)
    else $error("frame delivered with protocol none");
  word_hold_a: assert property (frame_valid_out && !frame_ready_in |=> frame_valid_out && $stable(frame_word_out))
    else $error("offered word withdrawn before it was taken");
endmodule
bind serial_port_frame_assembler serial_frame_asserts #(.CLK_FREQ_HZ(CLK_FREQ_HZ), .PORT_NUMBER(PORT_NUMBER),
  .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg_in), .cfg_load_in(cfg_load_in),
  .cfg_out(cfg_out), .cts_out(cts_out), .rts_active_out(rts_active_out), .rs485_mode_out(rs485_mode_out),
  .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in), .frame_word_out(frame_word_out),
  .dest_port_out(dest_port_out), .broadcast_out(broadcast_out), .overrun_out(overrun_out),
  .net_valid_in(net_valid_in), .net_ready_out(net_ready_out));

//--- sim/serial_terminal.sv
// Model of the attached terminal equipment that sends characters on the line.
`timescale 1ns/1ps
module serial_terminal
  import serial_frame_pkg::*;
#(
  parameter int CLK_FREQ_HZ = CLK_FREQ_HZ_DEF
) (
  input wire logic clk_in,
  output logic txd_out
);
  initial txd_out = 1'b1;
  // Sends one character; bad_par and bad_stop corrupt it on purpose.
  task automatic send(input logic [7:0] data, input port_cfg_type cfg, input logic bad_par, input logic bad_stop);
    int bit_len;
    logic par;
    logic q[$];
    bit_len = CLK_FREQ_HZ / BAUD_TABLE[cfg.baud_sel];
    q.push_back(1'b0);
    for (int i = 0; i < (cfg.seven_bits ? 7 : 8); i++) begin
      q.push_back(data[i]);
    end
    par = ^(cfg.seven_bits ? {1'b0, data[6:0]} : data);
    if (cfg.parity != PARITY_NONE) begin
      q.push_back((cfg.parity == PARITY_ODD) ? (!par ^ bad_par) : (par ^ bad_par));
    end
    if (cfg.two_stop) begin
      q.push_back(1'b1);
    end
    q.push_back(!bad_stop);
    @(posedge clk_in);
    foreach (q[i]) begin
      txd_out <= q[i];
      repeat (bit_len) @(posedge clk_in);
    end
    txd_out <= 1'b1;
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking testbench of the serial frame assembler.
`timescale 1ns/1ps
module tb_top;
  import serial_frame_pkg::*;
  localparam int SIM_CLK = 1_152_000;
  logic clk_in, reset_in, cfg_load_in, rts_in, frame_ready_in, net_valid_in, line, ovr_seen;
  logic cts_out, rts_active_out, rs485_mode_out, frame_valid_out, broadcast_out, overrun_out, net_ready_out;
  port_cfg_type cfg_in, cfg_out, cfg, c;
  frame_word_type frame_word_out;
  logic [15:0] dest_port_out;
  int miscompares = 0;
  int compares = 0;
  serial_port_frame_assembler #(.CLK_FREQ_HZ(SIM_CLK), .PORT_NUMBER(1), .FIFO_DEPTH(8)) i_dut (.clk_in(clk_in),
    .reset_in(reset_in), .cfg_in(cfg_in), .cfg_load_in(cfg_load_in), .cfg_out(cfg_out), .rxd_in(line),
    .rts_in(rts_in), .cts_out(cts_out), .rts_active_out(rts_active_out), .rs485_mode_out(rs485_mode_out),
    .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in), .frame_word_out(frame_word_out),
    .dest_port_out(dest_port_out), .broadcast_out(broadcast_out), .overrun_out(overrun_out),
    .net_valid_in(net_valid_in), .net_ready_out(net_ready_out));
  serial_terminal #(.CLK_FREQ_HZ(SIM_CLK)) i_term (.clk_in(clk_in), .txd_out(line));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (overrun_out === 1'b1) ovr_seen <= 1'b1;
  end
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic load(input port_cfg_type v);
    @(posedge clk_in);
    cfg_in <= v;
    cfg_load_in <= 1'b1;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    i_term.send(d, cfg, bad_par, bad_stop);
  endtask
  // Waits a bounded time for a word, compares it and takes it.
  task automatic pop(input frame_word_type exp);
    int n;
    n = 0;
    #1;
    while (frame_valid_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      $display("mismatch at %0t got %0h expected %0h", $time, 1'b0, 1'b1);
      close_out();
    end
    check(frame_word_out, exp);
    @(posedge clk_in);
    frame_ready_in <= 1'b1;
    @(posedge clk_in);
    frame_ready_in <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    cfg_load_in = 1'b0;
    cfg_in = CFG_DEF;
    rts_in = 1'b1;
    frame_ready_in = 1'b0;
    net_valid_in = 1'b1;
    ovr_seen = 1'b0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(cfg_out, CFG_DEF);
    check(cts_out, 1'b1);
    check(rts_active_out, 1'b0);
    check(net_ready_out, 1'b1);
    check(dest_port_out, 16'h22B1);
    cfg = CFG_DEF;
    cfg.baud_sel = 4'h9;
    load(cfg);
    send(8'h5A, 1'b0, 1'b0);
    repeat (800) @(posedge clk_in);
    #1;
    check(frame_valid_out, 1'b0);
    $display("test reset and discard done");
    c = cfg;
    c.baud_sel = 4'hF;
    c.idle_chars = 11'h7FF;
    c.max_size = 11'h000;
    c.parity = parity_type'(2'b11);
    load(c);
    check(cfg_out.baud_sel, 4'h6);
    check(cfg_out.idle_chars, 11'h7D0);
    check(cfg_out.max_size, 11'h001);
    check(cfg_out.parity, PARITY_NONE);
    $display("test clamping done");
    cfg.protocol_none = 1'b0;
    cfg.idle_chars = 11'h002;
    cfg.max_size = 11'h010;
    cfg.check_code = 1'b1;
    cfg.rs485_sel = 1'b1;
    cfg.bridge_mode = 1'b1;
    load(cfg);
    check(net_ready_out, 1'b0);
    check(rs485_mode_out, 1'b0);
    check(broadcast_out, 1'b1);
    for (int k = 0; k < 2; k++) begin
      send(8'h11, 1'b0, 1'b0);
      send(8'h22, 1'b0, 1'b0);
      send(8'(8'h33 + k), 1'b0, 1'b0);
      pop('{8'h11, 1'b0, 1'b0, 1'b0, 1'b1});
      pop('{8'h22, 1'b0, 1'b0, 1'b0, 1'b1});
      @(posedge clk_in);
      #1;
      check(frame_valid_out, 1'b0);
      pop('{8'(8'h33 + k), 1'b1, 1'b0, 1'b0, k == 0});
    end
    $display("test gap and check code done");
    cfg.check_code = 1'b0;
    cfg.max_size = 11'h002;
    cfg.idle_chars = 11'h005;
    load(cfg);
    for (int i = 0; i < 5; i++) send(8'(8'h01 + i), 1'b0, 1'b0);
    for (int i = 0; i < 5; i++) pop('{8'(8'h01 + i), (i % 2 == 1) || (i == 4), 1'b0, 1'b0, 1'b1});
    $display("test maximum size done");
    cfg.max_size = 11'h001;
    for (int k = 0; k < 6; k++) begin
      cfg.parity = parity_type'(k % 3);
      cfg.seven_bits = (k >= 3);
      load(cfg);
      send(8'hB5, k % 3 != 0, 1'b0);
      pop('{(k >= 3) ? 8'h35 : 8'hB5, 1'b1, k % 3 != 0, 1'b0, 1'b1});
    end
    cfg.parity = PARITY_NONE;
    cfg.seven_bits = 1'b0;
    cfg.two_stop = 1'b1;
    load(cfg);
    send(8'hC3, 1'b0, 1'b1);
    pop('{8'hC3, 1'b1, 1'b0, 1'b1, 1'b1});
    send(8'h3C, 1'b0, 1'b0);
    pop('{8'h3C, 1'b1, 1'b0, 1'b0, 1'b1});
    $display("test parity and stop bits done");
    cfg.two_stop = 1'b0;
    cfg.flow_rts_cts = 1'b1;
    load(cfg);
    repeat (5) @(posedge clk_in);
    #1;
    check(rts_active_out, 1'b1);
    for (int i = 0; i < 9; i++) send(8'(8'h40 + i), 1'b0, 1'b0);
    repeat (20) @(posedge clk_in);
    #1;
    check(cts_out, 1'b0);
    check(ovr_seen, 1'b1);
    for (int i = 0; i < 8; i++) pop('{8'(8'h40 + i), 1'b1, 1'b0, 1'b0, 1'b1});
    @(posedge clk_in);
    #1;
    check(cts_out, 1'b1);
    check(frame_valid_out, 1'b0);
    $display("test flow control done");
    close_out();
  end
endmodule
